// *** adc_chan_select.sv ***
// Configuration byte decoder and scan address stepper of the converter.
// Assumes the serial engine hands over each received byte as a one-cycle strobe,
// and the conversion sequencer pulses start and step on the same clock.
`timescale 1ns/1ps
module adc_chan_select #(
  parameter bit FOUR_CHAN = 1'b0
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  // Received bytes
  input wire logic BYTE_VALID_IN,
  input wire logic [7:0] BYTE_IN,
  // Conversion sequencer
  input wire logic SCAN_START_IN,
  input wire logic SCAN_STEP_IN,
  // Channel selection
  output logic [3:0] POS_SEL_OUT,
  output logic [3:0] NEG_SEL_OUT,
  output logic POS_GND_OUT,
  output logic NEG_GND_OUT,
  output logic CHAN_RESERVED_OUT,
  output logic CHAN_IGNORED_OUT,
  // Status
  output logic SCAN_BUSY_OUT,
  output logic SCAN_LAST_OUT,
  output logic [1:0] SCAN_MODE_OUT,
  output logic INPUT_TYPE_OUT
);
  import adc_cfg_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    scan_state_e state;
    logic [1:0] scan_mode;
    logic [3:0] chan_code;
    logic input_type_flag;
    logic [2:0] ref_sel;
    logic [3:0] addr;
    logic [3:0] limit;
    logic last;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic pos_gnd;
    logic neg_gnd;
    logic reserved;
    logic ignored;
  } sel_state_s;

  sel_state_s s_q;
  sel_state_s s_d;
  chan_map_if map_bus ();

  chan_mapper u_mapper (
    .m (map_bus.mapper)
  );

  logic [3:0] code_eff;
  logic [3:0] shared_pin;
  logic [3:0] start_addr;
  logic [3:0] stop_addr;
  logic [3:0] step;
  logic at_limit;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    if (BYTE_VALID_IN) begin
      if (!BYTE_IN[REG_BIT]) begin
        s_d.scan_mode = BYTE_IN[SCAN_HI_BIT:SCAN_LO_BIT];
        s_d.chan_code = BYTE_IN[CHAN_HI_BIT:CHAN_LO_BIT];
        s_d.input_type_flag = BYTE_IN[TYPE_BIT];
      end else begin
        s_d.ref_sel = BYTE_IN[SEL_HI_BIT:SEL_LO_BIT];
        if (!BYTE_IN[CFG_RESET_BIT]) begin
          s_d.scan_mode = SCAN_RESET;
          s_d.chan_code = CHAN_RESET;
          s_d.input_type_flag = TYPE_RESET;
        end
      end
    end

    // On the four-input variant the upper select bits are masked here so that nothing downstream sees them.
    code_eff = FOUR_CHAN ? {2'b00, s_d.chan_code[1:0]} : s_d.chan_code;
    shared_pin = FOUR_CHAN ? SHARED_PIN_NARROW : SHARED_PIN_WIDE;
    step = s_d.input_type_flag ? STEP_SINGLE : STEP_DIFF;
    start_addr = 4'h0;
    if (s_d.scan_mode == SCAN_UP_FROM_MID) begin
      start_addr = FOUR_CHAN ? MID_START_NARROW : MID_START_WIDE;
    end else if (s_d.scan_mode != SCAN_UP_FROM_ZERO) begin
      start_addr = code_eff;
    end
    stop_addr = (code_eff > LAST_INPUT) ? LAST_INPUT : code_eff;
    if (stop_addr < start_addr) begin
      stop_addr = start_addr;
    end
    // A reserved code as a single-conversion target is passed through unchanged.
    if (s_d.scan_mode == SCAN_REPEAT || s_d.scan_mode == SCAN_ONE) begin
      stop_addr = code_eff;
    end else if (s_d.input_type_flag && s_d.ref_sel[1] && stop_addr == shared_pin) begin
      stop_addr = shared_pin - 4'h1;
    end

    unique case (s_q.state)
      ST_IDLE: begin
        s_d.addr = code_eff;
        s_d.limit = stop_addr;
        if (SCAN_START_IN) begin
          s_d.state = ST_SCAN;
          s_d.addr = start_addr;
        end
      end
      ST_SCAN: begin
        if (SCAN_STEP_IN) begin
          if (s_q.last) begin
            s_d.state = ST_IDLE;
            s_d.addr = code_eff;
            s_d.limit = stop_addr;
          end else begin
            s_d.addr = s_q.addr + step;
          end
        end
      end
    endcase

    // Differential scans compare pair numbers only, so an odd limit ends on its pair.
    at_limit = s_d.input_type_flag ? (s_d.addr >= s_d.limit)
                                   : (s_d.addr[3:1] >= s_d.limit[3:1]);
    s_d.last = (s_d.state == ST_SCAN) && at_limit;

    map_bus.addr = s_d.addr;
    map_bus.single = s_d.input_type_flag;
    map_bus.ref_mid = s_d.ref_sel[1];
    map_bus.four_chan = FOUR_CHAN;
    s_d.pos_sel = map_bus.pos_sel;
    s_d.neg_sel = map_bus.neg_sel;
    s_d.pos_gnd = map_bus.pos_gnd;
    s_d.neg_gnd = map_bus.neg_gnd;
    s_d.reserved = map_bus.reserved;
    s_d.ignored = map_bus.ignored;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      s_q <= '{state: ST_IDLE, scan_mode: SCAN_RESET, chan_code: CHAN_RESET,
               input_type_flag: TYPE_RESET, ref_sel: SEL_RESET, addr: CHAN_RESET,
               limit: CHAN_RESET, last: 1'b0, pos_sel: CHAN_RESET, neg_sel: 4'h0,
               pos_gnd: 1'b0, neg_gnd: 1'b1, reserved: 1'b0, ignored: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign POS_SEL_OUT = s_q.pos_sel;
  assign NEG_SEL_OUT = s_q.neg_sel;
  assign POS_GND_OUT = s_q.pos_gnd;
  assign NEG_GND_OUT = s_q.neg_gnd;
  assign CHAN_RESERVED_OUT = s_q.reserved;
  assign CHAN_IGNORED_OUT = s_q.ignored;
  assign SCAN_BUSY_OUT = (s_q.state == ST_SCAN);
  assign SCAN_LAST_OUT = s_q.last;
  assign SCAN_MODE_OUT = s_q.scan_mode;
  assign INPUT_TYPE_OUT = s_q.input_type_flag;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);

  a_setup_keeps_cfg: assert property (
    BYTE_VALID_IN && BYTE_IN[7] && BYTE_IN[1]
    |=> SCAN_MODE_OUT == $past(SCAN_MODE_OUT) && s_q.chan_code == $past(s_q.chan_code))
    else $error("Setup byte changed the configuration.");
  a_scan_mode_load: assert property (
    BYTE_VALID_IN && !BYTE_IN[7] |=> SCAN_MODE_OUT == $past(BYTE_IN[6:5]))
    else $error("Scan mode not taken from the configuration byte.");
  a_chan_code_load: assert property (
    BYTE_VALID_IN && !BYTE_IN[7] |=> s_q.chan_code == $past(BYTE_IN[4:1]))
    else $error("Channel code not taken from the configuration byte.");
  a_narrow_upper_zero: assert property (
    FOUR_CHAN |-> POS_SEL_OUT[3:2] == 2'b00 && NEG_SEL_OUT[3:2] == 2'b00)
    else $error("Upper select bits set on the four-input variant.");
  a_type_flag_load: assert property (
    BYTE_VALID_IN && !BYTE_IN[7] |=> INPUT_TYPE_OUT == $past(BYTE_IN[0]))
    else $error("Input type flag not taken from the configuration byte.");
  a_single_to_ground: assert property (
    INPUT_TYPE_OUT |-> NEG_GND_OUT && !POS_GND_OUT && POS_SEL_OUT == s_q.addr)
    else $error("Single-ended selection not referred to ground.");
  a_diff_pairing: assert property (
    !INPUT_TYPE_OUT && !CHAN_RESERVED_OUT && !POS_GND_OUT && !NEG_GND_OUT
    |-> (POS_SEL_OUT ^ NEG_SEL_OUT) == 4'h1 && POS_SEL_OUT[0] == s_q.addr[0])
    else $error("Differential pair or polarity wrong.");
  a_ignore_needs_ref: assert property (
    CHAN_IGNORED_OUT |-> INPUT_TYPE_OUT && s_q.ref_sel[1])
    else $error("Shared pin ignored without reference selection.");
  a_ref_pair_ground: assert property (
    !INPUT_TYPE_OUT && s_q.ref_sel[1] && s_q.addr[3:1] == shared_pin[3:1]
    |-> POS_GND_OUT != NEG_GND_OUT)
    else $error("Reference pair does not use ground.");
  a_diff_step_two: assert property (
    SCAN_BUSY_OUT && !INPUT_TYPE_OUT && SCAN_STEP_IN && !SCAN_LAST_OUT && !BYTE_VALID_IN
    |=> s_q.addr == $past(s_q.addr) + 4'h2)
    else $error("Differential scan did not advance by two.");
  a_cfg_soft_reset: assert property (
    BYTE_VALID_IN && BYTE_IN[7] && !BYTE_IN[1]
    |=> SCAN_MODE_OUT == 2'h0 && s_q.chan_code == 4'h0 && INPUT_TYPE_OUT)
    else $error("Configuration not restored by the setup reset bit.");

  c_scan_done: cover property (SCAN_BUSY_OUT && SCAN_LAST_OUT && SCAN_STEP_IN);
  c_diff_step: cover property (SCAN_BUSY_OUT && !INPUT_TYPE_OUT && SCAN_STEP_IN);
  c_reserved_seen: cover property (CHAN_RESERVED_OUT);
  c_soft_reset: cover property (BYTE_VALID_IN && BYTE_IN[7] && !BYTE_IN[1]);

endmodule : adc_chan_select

// *** adc_cfg_pkg.sv ***
// Constants, field positions, power-up values and state types of the channel selector.
// Assumes a byte-wide write path on the same clock as the selector.
package adc_cfg_pkg;

  // ****************************************************************
  // Byte layout
  // ****************************************************************
  localparam int REG_BIT = 7;
  localparam int SCAN_HI_BIT = 6;
  localparam int SCAN_LO_BIT = 5;
  localparam int CHAN_HI_BIT = 4;
  localparam int CHAN_LO_BIT = 1;
  localparam int TYPE_BIT = 0;
  localparam int SEL_HI_BIT = 6;
  localparam int SEL_LO_BIT = 4;
  localparam int REF_MID_BIT = 5;
  localparam int CFG_RESET_BIT = 1;

  // ****************************************************************
  // Power-up values
  // ****************************************************************
  localparam logic [1:0] SCAN_RESET = 2'h0;
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic TYPE_RESET = 1'b1;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // ****************************************************************
  // Channel numbers and steps
  // ****************************************************************
  localparam logic [3:0] LAST_INPUT = 4'hb;
  localparam logic [3:0] SHARED_PIN_WIDE = 4'hb;
  localparam logic [3:0] SHARED_PIN_NARROW = 4'h3;
  localparam logic [3:0] MID_START_WIDE = 4'h6;
  localparam logic [3:0] MID_START_NARROW = 4'h2;
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_DIFF = 4'h2;
  localparam logic [1:0] SCAN_UP_FROM_ZERO = 2'h0;
  localparam logic [1:0] SCAN_REPEAT = 2'h1;
  localparam logic [1:0] SCAN_UP_FROM_MID = 2'h2;
  localparam logic [1:0] SCAN_ONE = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SCAN = 2'b10
  } scan_state_e;

endpackage : adc_cfg_pkg

// *** chan_map_if.sv ***
// Carrier between the selector core and its channel mapper.
// Assumes both ends sit in the same clock domain; the mapper is combinational.
`timescale 1ns/1ps
interface chan_map_if;
  logic [3:0] addr;
  logic single;
  logic ref_mid;
  logic four_chan;
  logic [3:0] pos_sel;
  logic [3:0] neg_sel;
  logic pos_gnd;
  logic neg_gnd;
  logic reserved;
  logic ignored;

  modport core (output addr, single, ref_mid, four_chan,
                input pos_sel, neg_sel, pos_gnd, neg_gnd, reserved, ignored);
  modport mapper (input addr, single, ref_mid, four_chan,
                  output pos_sel, neg_sel, pos_gnd, neg_gnd, reserved, ignored);
endinterface : chan_map_if

// *** chan_mapper.sv ***
// Turns a channel address into positive and negative input selections.
// Assumes the address already has its upper bits cleared on the four-input variant.
`timescale 1ns/1ps
module chan_mapper (
  chan_map_if.mapper m
);
  import adc_cfg_pkg::*;

  logic [3:0] shared_pin;
  logic [3:0] even_in;
  logic [3:0] odd_in;
  logic shared_pair;

  always_comb begin
    shared_pin = m.four_chan ? SHARED_PIN_NARROW : SHARED_PIN_WIDE;
    even_in = {m.addr[3:1], 1'b0};
    odd_in = {m.addr[3:1], 1'b1};
    shared_pair = m.ref_mid && (odd_in == shared_pin);
    m.reserved = (m.addr[3:2] == 2'b11);
    m.ignored = 1'b0;
    m.pos_gnd = 1'b0;
    m.neg_gnd = 1'b0;
    m.pos_sel = m.addr;
    m.neg_sel = 4'h0;
    if (m.single) begin
      m.neg_gnd = 1'b1;
      m.ignored = m.ref_mid && (m.addr == shared_pin) && !m.reserved;
    end else if (!m.reserved) begin
      // With the shared pin acting as reference, ground stands in for the odd input.
      if (shared_pair) begin
        m.pos_sel = m.addr[0] ? 4'h0 : even_in;
        m.neg_sel = m.addr[0] ? even_in : 4'h0;
        m.pos_gnd = m.addr[0];
        m.neg_gnd = !m.addr[0];
      end else begin
        m.pos_sel = m.addr[0] ? odd_in : even_in;
        m.neg_sel = m.addr[0] ? even_in : odd_in;
      end
    end
  end

endmodule : chan_mapper

// *** cfg_master.sv ***
// Bus-master model that hands configuration and setup bytes to the selector.
// Assumes the selector samples its byte strobe on the rising clock edge.
`timescale 1ns/1ps
module cfg_master (
  // Clock
  input wire logic clk_in,
  // Byte path
  output logic valid_out,
  output logic [7:0] byte_out
);
  // ****************************************************************
  // Byte writes
  // ****************************************************************
  initial begin
    valid_out = 1'b0;
    byte_out = 8'h00;
  end

  // Reserved channel codes go out only when a test hands one over.
  task automatic send(input logic [7:0] b);
    @(negedge clk_in);
    valid_out = 1'b1;
    byte_out = b;
    @(negedge clk_in);
    valid_out = 1'b0;
    // Junk outside the strobe, so a stale byte can never look valid.
    byte_out = ~b;
  endtask : send
endmodule : cfg_master

// *** testbench.sv ***
// Self-checking bench of the channel selector, wide and four-input variants.
// Assumes the selector package and the bus-master model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module testbench;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0;
  logic rst;
  logic start;
  logic step;
  logic bvalid;
  logic [7:0] bdata;
  logic [3:0] pos_sel, neg_sel, four_pos, four_neg;
  logic pos_gnd, neg_gnd, reserved, ignored, busy, last, itype, four_res;
  logic four_pgnd, four_ngnd, four_ign, four_busy, four_last, four_type;
  logic [1:0] mode, four_mode;
  int num_errors = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  cfg_master cfg_master_inst (.clk_in(clk), .valid_out(bvalid), .byte_out(bdata));

  adc_chan_select adc_chan_select_inst (.CLOCK_IN(clk), .RESET_IN(rst),
    .BYTE_VALID_IN(bvalid), .BYTE_IN(bdata), .SCAN_START_IN(start), .SCAN_STEP_IN(step),
    .POS_SEL_OUT(pos_sel), .NEG_SEL_OUT(neg_sel), .POS_GND_OUT(pos_gnd),
    .NEG_GND_OUT(neg_gnd), .CHAN_RESERVED_OUT(reserved), .CHAN_IGNORED_OUT(ignored),
    .SCAN_BUSY_OUT(busy), .SCAN_LAST_OUT(last), .SCAN_MODE_OUT(mode),
    .INPUT_TYPE_OUT(itype));

  adc_chan_select #(.FOUR_CHAN(1'b1)) adc_chan_select_four_inst (.CLOCK_IN(clk),
    .RESET_IN(rst), .BYTE_VALID_IN(bvalid), .BYTE_IN(bdata), .SCAN_START_IN(start),
    .SCAN_STEP_IN(step), .POS_SEL_OUT(four_pos), .NEG_SEL_OUT(four_neg),
    .POS_GND_OUT(four_pgnd), .NEG_GND_OUT(four_ngnd), .CHAN_RESERVED_OUT(four_res),
    .CHAN_IGNORED_OUT(four_ign), .SCAN_BUSY_OUT(four_busy), .SCAN_LAST_OUT(four_last),
    .SCAN_MODE_OUT(four_mode), .INPUT_TYPE_OUT(four_type));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // One-cycle pulse of start (go set) or step; outputs are settled on return.
  task automatic strobe(input bit go);
    @(negedge clk);
    if (go) start = 1'b1;
    else step = 1'b1;
    @(negedge clk);
    start = 1'b0;
    step = 1'b0;
  endtask : strobe

  task automatic sel_chk(input logic [3:0] p, input logic pg, input logic ng);
    `CHK("pos_sel", p, pos_sel)
    `CHK("pos_gnd", pg, pos_gnd)
    `CHK("neg_gnd", ng, neg_gnd)
  endtask : sel_chk

  // The loop bound doubles as the hang guard: a scan that never ends fails.
  // The four-input copy sees the same strobes and ends after n4 addresses.
  task automatic scan(input logic [3:0] first, input logic [3:0] inc, input int n,
                      input logic [3:0] first4, input int n4);
    int i;
    strobe(1'b1);
    `CHK("busy", 1'b1, busy)
    `CHK("four busy", 1'b1, four_busy)
    for (i = 0; i < 16 && busy === 1'b1; i++) begin
      `CHK("scan pos", 4'(first + inc * i[3:0]), pos_sel)
      `CHK("scan last", 1'(i == n - 1), last)
      `CHK("four busy", 1'(i < n4), four_busy)
      if (i < n4) begin
        `CHK("four pos", 4'(first4 + inc * i[3:0]), four_pos)
        `CHK("four last", 1'(i == n4 - 1), four_last)
      end
      strobe(1'b0);
    end
    `CHK("scan count", n, i)
    if (i == 16) print_verdict();
  endtask : scan

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int c;
    rst = 1'b1;
    start = 1'b0;
    step = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    `CHK("mode", 2'h0, mode)
    `CHK("type", 1'b1, itype)
    `CHK("four type", 1'b1, four_type)
    sel_chk(4'h0, 1'b0, 1'b1);
    for (c = 0; c < 16; c++) begin
      cfg_master_inst.send({3'h0, c[3:0], 1'b1});
      sel_chk(c[3:0], 1'b0, 1'b1);
      `CHK("reserved", 1'(c >= 12), reserved)
      `CHK("not ignored", 1'b0, ignored)
      `CHK("four single pos", {2'h0, c[1:0]}, four_pos)
    end
    `CHK("four pos", 4'h3, four_pos)
    `CHK("four reserved", 1'b0, four_res)
    for (c = 0; c < 12; c++) begin
      cfg_master_inst.send({3'h0, c[3:0], 1'b0});
      sel_chk(c[3:0], 1'b0, 1'b0);
      `CHK("neg_sel", 4'(c[3:0] ^ 4'h1), neg_sel)
      `CHK("four neg", {2'h0, c[1:0] ^ 2'h1}, four_neg)
    end
    `CHK("diff type", 1'b0, itype)
    `CHK("four diff type", 1'b0, four_type)
    cfg_master_inst.send(8'h4d);
    cfg_master_inst.send(8'h82);
    `CHK("mode kept", 2'h2, mode)
    `CHK("four mode kept", 2'h2, four_mode)
    cfg_master_inst.send(8'h80);
    `CHK("mode def", 2'h0, mode)
    sel_chk(4'h0, 1'b0, 1'b1);
    cfg_master_inst.send(8'ha2);
    cfg_master_inst.send(8'h17);
    `CHK("ignored", 1'b1, ignored)
    `CHK("four ignored", 1'b1, four_ign)
    cfg_master_inst.send(8'h14);
    sel_chk(4'ha, 1'b0, 1'b1);
    `CHK("four ref pos", 4'h2, four_pos)
    `CHK("four ref neg_gnd", 1'b1, four_ngnd)
    cfg_master_inst.send(8'h16);
    `CHK("ref pos_gnd", 1'b1, pos_gnd)
    `CHK("ref neg", 4'ha, neg_sel)
    `CHK("ref neg_gnd", 1'b0, neg_gnd)
    `CHK("four ref pos_gnd", 1'b1, four_pgnd)
    `CHK("four ref neg", 4'h2, four_neg)
    cfg_master_inst.send(8'h17);
    scan(4'h0, 4'h1, 11, 4'h0, 3);
    cfg_master_inst.send(8'h82);
    cfg_master_inst.send(8'h14);
    scan(4'h0, 4'h2, 6, 4'h0, 2);
    cfg_master_inst.send(8'h51);
    scan(4'h6, 4'h1, 3, 4'h2, 1);
    cfg_master_inst.send(8'h2b);
    scan(4'h5, 4'h1, 1, 4'h1, 1);
    cfg_master_inst.send(8'h6b);
    scan(4'h5, 4'h1, 1, 4'h1, 1);
    // A second reset from a non-default configuration.
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK("reset mode", 2'h0, mode)
    `CHK("reset type", 1'b1, itype)
    `CHK("reset busy", 1'b0, busy)
    sel_chk(4'h0, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : testbench
